/* File: hdl/sifm_pkg.sv */
// ==========================================================
// Constants and types of the input function mapper
package sifm_pkg;
   // ==========================================================
   // Sizes
   localparam int SIFM_NIN = 8;  // Physical digital inputs
   localparam int SIFM_NFN = 12; // Decoded functions
   // ==========================================================
   // APB byte offsets
   localparam logic [7:0] SIFM_OFF_MODE = 8'h00;  // Mode setting
   localparam logic [7:0] SIFM_OFF_ACT = 8'h04;   // Active mode, restart
   localparam logic [7:0] SIFM_OFF_SPEED_SELECT_BIT1 = 8'h08;  // Internal speed one
   localparam logic [7:0] SIFM_OFF_SPD2 = 8'h0c;  // Internal speed two
   localparam logic [7:0] SIFM_OFF_SPD3 = 8'h10;  // Internal speed three
   localparam logic [7:0] SIFM_OFF_STAT = 8'h14;  // Live status
   localparam logic [7:0] SIFM_OFF_IRQ = 8'h18;   // Sticky events, W1C
   localparam logic [7:0] SIFM_OFF_MASK = 8'h1c;  // Event mask
   localparam logic [2:0] SIFM_FUNC_PAGE = 3'h1;  // 0x20..0x3c settings
   // ==========================================================
   // Values after reset
   localparam logic [7:0] SIFM_RST_MODE = 8'h02;
   localparam logic [7:0][7:0] SIFM_RST_FUNC = {
      8'h15, 8'h17, 8'h16, 8'h66, 8'h73, 8'h72, 8'h6d, 8'h65};
   localparam logic [15:0] SIFM_RST_SPD = 16'h0000;
   // ==========================================================
   // Mode setting values
   localparam logic [7:0] SIFM_SET_POS = 8'h01;
   localparam logic [7:0] SIFM_SET_SPEED = 8'h02;
   // ==========================================================
   // Function indices and their codes
   localparam int SIFM_FN_SON = 0;
   localparam int SIFM_FN_TRQ = 1;
   localparam int SIFM_FN_SPEED_SELECT_BIT0 = 2;
   localparam int SIFM_FN_SPEED_SELECT_BIT1 = 3;
   localparam int SIFM_FN_ALARM_CLEAR_INPUT = 4;
   localparam int SIFM_FN_POSITION_COMMAND_TRIGGER = 5;
   localparam int SIFM_FN_POSITION_SELECT_BIT0 = 6;
   localparam int SIFM_FN_POSITION_SELECT_BIT1 = 7;
   localparam int SIFM_FN_POSITION_SELECT_BIT2 = 8;
   localparam int SIFM_FN_EMG = 9;
   localparam int SIFM_FN_RLIM = 10;
   localparam int SIFM_FN_FLIM = 11;
   localparam logic [11:0][7:0] SIFM_FN_CODE = {
      8'h17, 8'h16, 8'h15, 8'h71, 8'h70, 8'h6f,
      8'h6c, 8'h66, 8'h73, 8'h72, 8'h6d, 8'h65};
   localparam logic [11:0] SIFM_FN_SPD_ONLY = 12'h00e;
   localparam logic [11:0] SIFM_FN_POS_ONLY = 12'h1e0;
   // ==========================================================
   // Fault codes and speed limits
   localparam logic [7:0] SIFM_FLT_NONE = 8'h00;
   localparam logic [7:0] SIFM_FLT_RLIM = 8'h0d;
   localparam logic [7:0] SIFM_FLT_FLIM = 8'h0e;
   localparam logic [7:0] SIFM_FLT_EMG = 8'h0f;
   localparam logic signed [15:0] SIFM_SPD_MAX = 16'sh1388;
   localparam logic signed [15:0] SIFM_SPD_MIN = -16'sh1388;
   // ==========================================================
   // Event bits
   localparam int SIFM_EV_FAULT = 0;
   localparam int SIFM_EV_TRIG = 1;
   localparam int SIFM_EV_SEL = 2;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      SIFM_MODE_NONE = 2'b00,
      SIFM_MODE_POS = 2'b01,
      SIFM_MODE_SPEED = 2'b10
   } sifm_mode_t;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } sifm_apb_rsp_t;
   typedef struct packed {
      logic servo_on;
      logic trq_lim;
      logic use_analog;
      logic dir_ccw;
      logic [1:0] spd_sel;
      logic [15:0] speed_cmd;
      logic [2:0] pos_sel;
      logic pos_trig;
      logic [7:0] fault;
      logic irq;
   } sifm_drive_t;
   typedef struct packed {
      logic [7:0] din_s1;
      logic [7:0] din_s2;
      logic alarm_clear_input_prev;
      logic position_command_trigger_prev;
      logic [7:0] mode_set;
      sifm_mode_t mode_act;
      logic [7:0][7:0] func;
      logic [2:0][15:0] spd;
      logic [2:0] irq_st;
      logic [2:0] irq_mask;
      sifm_apb_rsp_t apb;
      sifm_drive_t drv;
   } sifm_state_t;
endpackage

/* File: hdl/sifm_mapper.sv */
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
module sifm_mapper
   import sifm_pkg::*;
(
   // Clock, enable and reset
   input wire logic CLK,
   input wire logic CE,
   input wire logic NRST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Digital input pins and analog reference
   input wire logic [7:0] DIN,
   input wire logic [15:0] ANALOG_REF,
   // Speed loop commands
   output logic SERVO_ON,
   output logic TORQUE_LIMIT,
   output logic USE_ANALOG,
   output logic DIR_CCW,
   output logic [1:0] SPEED_SEL,
   output logic [15:0] SPEED_CMD,
   // Position commands
   output logic [2:0] POS_SEL,
   output logic POS_TRIG,
   // Fault and interrupt
   output logic [7:0] FAULT_CODE,
   output logic IRQ
);

   // ==========================================================
   // Declarations
   // All state sits in one struct, so one register stage holds it
   // and CE low freezes it as a whole
   sifm_state_t s_q; // Whole registered state
   sifm_state_t s_d; // Its next value
   // Per input: which function its setting names
   // One row per input, one column per function; a row has no bit
   // set when its setting is zero or an unknown code
   logic [SIFM_NIN-1:0][SIFM_NFN-1:0] asg;

   // ==========================================================
   // Clamp a written speed to the legal range
   // Saturating on the write keeps the stored value legal, so a
   // read back shows what the speed loop really gets
   function automatic logic [15:0] clamp_spd(input logic [15:0] w);
      logic signed [15:0] v;
      v = signed'(w);
      if (v > SIFM_SPD_MAX) begin
         clamp_spd = SIFM_SPD_MAX;
      end else if (v < SIFM_SPD_MIN) begin
         clamp_spd = SIFM_SPD_MIN;
      end else begin
         clamp_spd = w;
      end
   endfunction

   // ==========================================================
   // Map a mode setting to the mode it selects
   // Any other setting selects no mode, so no mode-specific code
   // acts until a valid setting is restarted
   function automatic sifm_mode_t dec_mode(input logic [7:0] m);
      if (m == SIFM_SET_SPEED) begin
         dec_mode = SIFM_MODE_SPEED;
      end else if (m == SIFM_SET_POS) begin
         dec_mode = SIFM_MODE_POS;
      end else begin
         dec_mode = SIFM_MODE_NONE;
      end
   endfunction

   // ==========================================================
   // Function match, one comparator per input and function.
   // No code is zero, so a zero setting matches nothing.
   // A full grid of comparators costs area, but any code may then
   // sit on any input with no priority between inputs
   for (genvar i = 0; i < SIFM_NIN; i++) begin : g_in
      for (genvar f = 0; f < SIFM_NFN; f++) begin : g_fn
         assign asg[i][f] = (s_q.func[i] == SIFM_FN_CODE[f]);
      end
   end

   // ==========================================================
   // Next-state logic
   always_comb begin
      // Working values of this pass; each starts from a fixed value
      // so that no path leaves a latch behind
      logic [SIFM_NFN-1:0] fn_asg;
      logic [SIFM_NFN-1:0] fn_on;
      logic [31:0] rd;
      logic hit;
      logic wr;
      logic restart;
      logic alarm_clear_input_rise;
      logic [7:0] flt_new;
      logic [2:0] ev;
      logic [15:0] cmd;
      fn_asg = '0;
      fn_on = '0;
      rd = '0;
      hit = 1'b1;
      wr = 1'b0;
      restart = 1'b0;
      alarm_clear_input_rise = 1'b0;
      flt_new = SIFM_FLT_NONE;
      ev = '0;
      cmd = '0;
      s_d = s_q;

      // Two flops per pin; only the second is decoded
      // The first flop may go metastable; contact bounce is not
      // filtered here, the controller must give clean levels
      s_d.din_s1 = DIN;
      s_d.din_s2 = s_q.din_s1;

      // Gather functions over all inputs; ON is a one
      // Inputs that share a code are ORed, so a function is ON when
      // any of its inputs is closed
      for (int i = 0; i < SIFM_NIN; i++) begin
         fn_asg = fn_asg | asg[i];
         fn_on = fn_on | (asg[i] & {SIFM_NFN{s_q.din_s2[i]}});
      end
      // Mode-specific codes are ignored in the other mode
      // Torque and speed select count in speed mode only, trigger
      // and position select in position mode only
      if (s_q.mode_act != SIFM_MODE_SPEED) begin
         fn_on = fn_on & ~SIFM_FN_SPD_ONLY;
      end
      if (s_q.mode_act != SIFM_MODE_POS) begin
         fn_on = fn_on & ~SIFM_FN_POS_ONLY;
      end

      // APB setup cycle: decode and prepare the answer
      // Ready and error stand for the access cycle only; read data
      // stays until the next setup
      s_d.apb.pready = 1'b0;
      s_d.apb.pslverr = 1'b0;
      // A setup seen while ready still stands is not taken, so one
      // transfer is never answered twice
      if (PSEL && !PENABLE && !s_q.apb.pready) begin
         if (PADDR == SIFM_OFF_MODE) begin
            rd[7:0] = s_q.mode_set;
         end else if (PADDR == SIFM_OFF_ACT) begin
            rd[1:0] = s_q.mode_act;
         end else if (PADDR == SIFM_OFF_SPEED_SELECT_BIT1) begin
            rd[15:0] = s_q.spd[0];
         end else if (PADDR == SIFM_OFF_SPD2) begin
            rd[15:0] = s_q.spd[1];
         end else if (PADDR == SIFM_OFF_SPD3) begin
            rd[15:0] = s_q.spd[2];
         end else if (PADDR == SIFM_OFF_STAT) begin
            rd[7:0] = s_q.din_s2;
            rd[9:8] = s_q.mode_act;
            rd[12] = s_q.drv.servo_on;
            rd[23:16] = s_q.drv.fault;
         end else if (PADDR == SIFM_OFF_IRQ) begin
            rd[2:0] = s_q.irq_st;
         end else if (PADDR == SIFM_OFF_MASK) begin
            rd[2:0] = s_q.irq_mask;
         end else if (PADDR[7:5] == SIFM_FUNC_PAGE && PADDR[1:0] == 2'h0) begin
            rd[7:0] = s_q.func[PADDR[4:2]];
         end else begin
            hit = 1'b0; // Unmapped: error answer
         end
         s_d.apb.pready = 1'b1;
         s_d.apb.pslverr = !hit;
         s_d.apb.prdata = rd;
      end
      // Access phase with ready high: the write lands here
      // An error answer blocks the write, so an unmapped address
      // leaves every register as it was
      wr = PSEL && PENABLE && s_q.apb.pready && PWRITE && !s_q.apb.pslverr;

      // Register writes
      // Live status is read only and has no branch; the event
      // register is handled with the sticky bits further down
      if (wr) begin
         if (PADDR == SIFM_OFF_MODE) begin
            s_d.mode_set = PWDATA[7:0]; // Not used until restart
         end else if (PADDR == SIFM_OFF_ACT) begin
            restart = PWDATA[0];
         end else if (PADDR == SIFM_OFF_SPEED_SELECT_BIT1) begin
            s_d.spd[0] = clamp_spd(PWDATA[15:0]);
         end else if (PADDR == SIFM_OFF_SPD2) begin
            s_d.spd[1] = clamp_spd(PWDATA[15:0]);
         end else if (PADDR == SIFM_OFF_SPD3) begin
            s_d.spd[2] = clamp_spd(PWDATA[15:0]);
         end else if (PADDR == SIFM_OFF_MASK) begin
            s_d.irq_mask = PWDATA[2:0];
         end else if (PADDR[7:5] == SIFM_FUNC_PAGE) begin
            // Any code on any input, incl. 113 on input five
            s_d.func[PADDR[4:2]] = PWDATA[7:0];
         end
      end

      // Restart stands in for a power cycle of the mode
      // It loads the mode and clears the fault; functions and speeds keep the
      // values that the controller configured
      if (restart) begin
         s_d.mode_act = dec_mode(s_q.mode_set);
      end

      // Alarm reset acts on its rising edge only
      // A held reset input must not clear a fault that comes back
      // later, so a new press is needed each time
      s_d.alarm_clear_input_prev = fn_on[SIFM_FN_ALARM_CLEAR_INPUT];
      alarm_clear_input_rise = fn_on[SIFM_FN_ALARM_CLEAR_INPUT] && !s_q.alarm_clear_input_prev;

      // Limit and stop inputs fault while their contact is open
      // Contacts are normally closed, so a broken wire also stops
      // the drive; reverse wins over forward, forward over stop
      if (fn_asg[SIFM_FN_RLIM] && !fn_on[SIFM_FN_RLIM]) begin
         flt_new = SIFM_FLT_RLIM;
      end else if (fn_asg[SIFM_FN_FLIM] && !fn_on[SIFM_FN_FLIM]) begin
         flt_new = SIFM_FLT_FLIM;
      end else if (fn_asg[SIFM_FN_EMG] && !fn_on[SIFM_FN_EMG]) begin
         flt_new = SIFM_FLT_EMG;
      end

      // Clear first, then a live condition sets again
      // A clear thus never hides a limit that is still open
      if (alarm_clear_input_rise || restart) begin
         s_d.drv.fault = SIFM_FLT_NONE;
      end
      // A latched code stays until cleared; a second condition
      // does not overwrite the first one
      if (flt_new != SIFM_FLT_NONE && s_d.drv.fault == SIFM_FLT_NONE) begin
         s_d.drv.fault = flt_new;
         ev[SIFM_EV_FAULT] = 1'b1;
      end

      // Servo enable from the controller, blocked by a fault
      // The servo drops on the same edge at which a fault is set
      s_d.drv.servo_on = fn_on[SIFM_FN_SON] &&
                         (s_d.drv.fault == SIFM_FLT_NONE);
      s_d.drv.trq_lim = fn_on[SIFM_FN_TRQ];

      // Speed reference select
      // A change of select bits is an event, so software can see
      // that the reference source moved
      s_d.drv.spd_sel = {fn_on[SIFM_FN_SPEED_SELECT_BIT1], fn_on[SIFM_FN_SPEED_SELECT_BIT0]};
      if (s_d.drv.spd_sel != s_q.drv.spd_sel) begin
         ev[SIFM_EV_SEL] = 1'b1;
      end
      s_d.drv.use_analog = (s_d.drv.spd_sel == 2'b00);
      // The analog path is not clamped: its range is set by the
      // converter ahead of this block
      case (s_d.drv.spd_sel)
         2'b00: cmd = ANALOG_REF;
         2'b01: cmd = s_q.spd[0];
         2'b10: cmd = s_q.spd[1];
         default: cmd = s_q.spd[2];
      endcase
      // Without servo on or outside speed mode, no speed
      if (!s_d.drv.servo_on || s_q.mode_act != SIFM_MODE_SPEED) begin
         cmd = '0;
      end
      s_d.drv.speed_cmd = cmd;
      // Sign bit clear and nonzero turns counterclockwise
      s_d.drv.dir_ccw = !cmd[15] && (cmd != 16'h0000);

      // Position select follows the bits; trigger on a rising edge
      // A trigger while the servo is off is lost and must be given
      // again once the servo is on
      s_d.drv.pos_sel = {fn_on[SIFM_FN_POSITION_SELECT_BIT2], fn_on[SIFM_FN_POSITION_SELECT_BIT1],
                         fn_on[SIFM_FN_POSITION_SELECT_BIT0]};
      s_d.position_command_trigger_prev = fn_on[SIFM_FN_POSITION_COMMAND_TRIGGER];
      s_d.drv.pos_trig = fn_on[SIFM_FN_POSITION_COMMAND_TRIGGER] && !s_q.position_command_trigger_prev &&
                         s_d.drv.servo_on;
      if (s_d.drv.pos_trig) begin
         ev[SIFM_EV_TRIG] = 1'b1;
      end

      // Sticky events: a new event wins over the clear
      // The clear goes first and new events are ORed in after it,
      // so an event in the clear cycle is kept
      if (wr && PADDR == SIFM_OFF_IRQ) begin
         s_d.irq_st = s_q.irq_st & ~PWDATA[2:0];
      end
      s_d.irq_st = s_d.irq_st | ev;
      s_d.drv.irq = |(s_d.irq_st & s_d.irq_mask);

      // Synchronous reset overrides all of the above
      // Defaults: speed mode, limits and stop on inputs six to
      // eight, speeds zero, mask zero, no fault latched
      if (!NRST) begin
         s_d = '0;
         s_d.mode_set = SIFM_RST_MODE;
         s_d.mode_act = dec_mode(SIFM_RST_MODE);
         s_d.func = SIFM_RST_FUNC;
         s_d.spd = {3{SIFM_RST_SPD}};
      end
   end

   // ==========================================================
   // State register; CE low freezes everything, reset included
   // A reset must therefore be given while the clock is enabled
   always_ff @(posedge CLK) begin
      if (CE) begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs straight from the state register
   // No logic between register and pins, so every output moves
   // only at a clock edge and never glitches
   assign PRDATA = s_q.apb.prdata;
   assign PREADY = s_q.apb.pready;
   assign PSLVERR = s_q.apb.pslverr;
   assign SERVO_ON = s_q.drv.servo_on;
   assign TORQUE_LIMIT = s_q.drv.trq_lim;
   assign USE_ANALOG = s_q.drv.use_analog;
   assign DIR_CCW = s_q.drv.dir_ccw;
   assign SPEED_SEL = s_q.drv.spd_sel;
   assign SPEED_CMD = s_q.drv.speed_cmd;
   assign POS_SEL = s_q.drv.pos_sel;
   assign POS_TRIG = s_q.drv.pos_trig;
   assign FAULT_CODE = s_q.drv.fault;
   assign IRQ = s_q.drv.irq;

endmodule

/* File: bench/sifm_mapper_assertions.sv */
`timescale 1ns/1ps
// ==========================================================
// Port-level checks of the input function mapper
module sifm_mapper_checker
   import sifm_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // Bus handshake
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // Pins and drive commands
   input wire logic [7:0] DIN,
   input wire logic SERVO_ON,
   input wire logic USE_ANALOG,
   input wire logic DIR_CCW,
   input wire logic [1:0] SPEED_SEL,
   input wire logic [15:0] SPEED_CMD,
   input wire logic [2:0] POS_SEL,
   input wire logic POS_TRIG,
   input wire logic [7:0] FAULT_CODE
);
   // ==========================================================
   // One domain, so one default clock and reset
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   a_apb_ready_next: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");
   a_error_with_ready: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   a_fault_stops_servo: assert property (FAULT_CODE != 8'h00 |-> !SERVO_ON)
      else $error("servo on during fault");
   a_fault_code_set: assert property (FAULT_CODE inside {8'h00, 8'h0d, 8'h0e, 8'h0f})
      else $error("unknown fault code");
   a_direction_sign: assert property (DIR_CCW == ($signed(SPEED_CMD) > 0))
      else $error("direction disagrees with sign");
   a_speed_clamp: assert property (!USE_ANALOG |->
      $signed(SPEED_CMD) <= SIFM_SPD_MAX && $signed(SPEED_CMD) >= SIFM_SPD_MIN)
      else $error("internal speed beyond limit");
   a_trigger_pulse: assert property (POS_TRIG |=> !POS_TRIG)
      else $error("trigger longer than a cycle");
   a_trigger_servo: assert property (POS_TRIG |-> SERVO_ON)
      else $error("trigger while servo off");
   a_mode_exclusive: assert property (SPEED_SEL != 2'b00 |-> POS_SEL == 3'b000)
      else $error("speed and position selects together");
   // Five quiet cycles cover the two sync flops plus the output stage
   a_sync_settle: assert property (($stable(DIN) && !PSEL) [*5] |->
      $stable(SPEED_SEL) && $stable(POS_SEL))
      else $error("select moved with pins quiet");
endmodule
bind sifm_mapper sifm_mapper_checker chk_u (
   .CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .DIN(DIN), .SERVO_ON(SERVO_ON), .USE_ANALOG(USE_ANALOG),
   .DIR_CCW(DIR_CCW), .SPEED_SEL(SPEED_SEL), .SPEED_CMD(SPEED_CMD), .POS_SEL(POS_SEL),
   .POS_TRIG(POS_TRIG), .FAULT_CODE(FAULT_CODE));

/* File: bench/sifm_ctrl_model.sv */
`timescale 1ns/1ps
// ==========================================================
// External controller driving the contact inputs
module sifm_ctrl_model (
   // Clock
   input wire logic clk,
   // Requested contact states, bit 0 is input one
   input wire logic [7:0] pins_req,
   // Contact levels, 1 means closed
   output logic [7:0] din
);
   // Contacts move just after an edge, never mid-cycle; they are
   // unknown only until the first edge, which falls inside reset
   always @(posedge clk) begin
      din <= pins_req;
   end
endmodule

/* File: bench/servo_input_function_mapper_test.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench of the input function mapper
module servo_input_function_mapper_test
   import sifm_pkg::*;
;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [7:0] req = 8'h00; // Contact states asked of the controller
   wire logic [7:0] din;
   logic [31:0] prdata, rd;
   logic pready, pslverr, servo_on, trq, use_an, dir_ccw, pos_trig, irq, err;
   logic [1:0] spd_sel;
   logic [15:0] spd_cmd;
   logic [2:0] pos_sel;
   logic [7:0] fault;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #2.5 clk = ~clk;
   // ==========================================================
   // Controller model and design; analog reference held steady
   sifm_ctrl_model ctl_u (.clk(clk), .pins_req(req), .din(din));
   sifm_mapper dut_u (
      .CLK(clk), .CE(1'b1), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .DIN(din), .ANALOG_REF(16'h04d2), .SERVO_ON(servo_on), .TORQUE_LIMIT(trq),
      .USE_ANALOG(use_an), .DIR_CCW(dir_ccw), .SPEED_SEL(spd_sel), .SPEED_CMD(spd_cmd),
      .POS_SEL(pos_sel), .POS_TRIG(pos_trig), .FAULT_CODE(fault), .IRQ(irq));
   // ==========================================================
   // Shared tasks
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", w, e, g);
      end
   endtask
   // Ready is taken at the rising edge, before that edge's update lands
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int guard;
      guard = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         guard++;
      end while (pready !== 1'b1 && guard < 50);
      if (guard >= 50) n_mismatch++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd, err);
   endtask
   task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, rd, err);
      chk(w, e, rd);
   endtask
   // Pin change, then wait out model, two sync flops and output stage
   task automatic pins(input logic [7:0] v);
      @(posedge clk);
      req <= v;
      repeat (5) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic settle();
      repeat (2) @(negedge clk);
   endtask
   // Rising edge on input five, limits held closed
   task automatic alarm_clear();
      pins(8'he0);
      pins(8'hf0);
      pins(8'he0);
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      rdc("mode", SIFM_OFF_MODE, 32'h02);
      rdc("active", SIFM_OFF_ACT, 32'h2);
      rdc("func1", 8'h20, 32'h65);
      rdc("func8", 8'h3c, 32'h15);
      rdc("speed1", SIFM_OFF_SPEED_SELECT_BIT1, 32'h0);
      rdc("unmapped", 8'hfc, 32'h0);
      chk("slverr", 32'h1, 32'(err));
      pins(8'h00);
      chk("fault", 32'h0d, 32'(fault));
      $display("test reset done");
   endtask
   task automatic t_fault();
      logic [7:0] p [3] = '{8'h00, 8'h60, 8'ha0};
      logic [7:0] f [3] = '{8'h0d, 8'h0f, 8'h0e};
      wr(SIFM_OFF_MASK, 32'h1);
      for (int i = 0; i < 3; i++) begin
         pins(p[i]);
         chk("fault", 32'(f[i]), 32'(fault));
         chk("irq on", 32'h1, 32'(irq));
         alarm_clear();
         chk("cleared", 32'h0, 32'(fault));
         wr(SIFM_OFF_IRQ, 32'h7);
         settle();
         chk("irq off", 32'h0, 32'(irq));
      end
      pins(8'h60);
      wr(SIFM_OFF_MASK, 32'h0);
      settle();
      chk("masked", 32'h0, 32'(irq));
      alarm_clear();
      wr(SIFM_OFF_IRQ, 32'h7);
      $display("test fault done");
   endtask
   task automatic t_disable();
      for (int i = 5; i < 8; i++) wr(8'h20 + 8'(4 * i), 32'h0);
      pins(8'h00);
      chk("disabled", 32'h0, 32'(fault));
      $display("test disable done");
   endtask
   task automatic t_speed();
      logic [15:0] e [4] = '{16'h04d2, 16'h0bb8, 16'h0064, 16'hf448};
      wr(SIFM_OFF_SPEED_SELECT_BIT1, 32'h0bb8);
      wr(SIFM_OFF_SPD2, 32'h0064);
      wr(SIFM_OFF_SPD3, 32'h1770);
      rdc("clamp", SIFM_OFF_SPD3, 32'h1388);
      wr(SIFM_OFF_SPD3, 32'h0000f448);
      for (int s = 0; s < 4; s++) begin
         pins(8'h01 | 8'(s << 2));
         chk("select", 32'(s), 32'(spd_sel));
         chk("speed", 32'(e[s]), 32'(spd_cmd));
         chk("ccw", 32'(s != 3), 32'(dir_ccw));
         chk("analog", 32'(s == 0), 32'(use_an));
      end
      pins(8'h03);
      chk("torque", 32'h1, 32'(trq));
      pins(8'h0c);
      chk("servo off", 32'h0, 32'(servo_on));
      chk("no speed", 32'h0, 32'(spd_cmd));
      $display("test speed done");
   endtask
   task automatic t_remap();
      wr(8'h3c, 32'h72);
      pins(8'h81);
      chk("remap", 32'h1, 32'(spd_sel));
      wr(8'h3c, 32'h0);
      $display("test remap done");
   endtask
   task automatic t_pos();
      logic [7:0] c [8] = '{8'h65, 8'h6c, 8'h6f, 8'h70, 8'h71, 8'h6d, 8'h00, 8'h00};
      int n;
      n = 0;
      wr(SIFM_OFF_MODE, 32'h01);
      rdc("held", SIFM_OFF_ACT, 32'h2);
      wr(SIFM_OFF_ACT, 32'h1);
      rdc("position", SIFM_OFF_ACT, 32'h1);
      // Limits off and alarm cleared first, in case restart restored them
      for (int i = 5; i < 8; i++) wr(8'h20 + 8'(4 * i), 32'(c[i]));
      pins(8'h10);
      pins(8'h00);
      for (int i = 1; i < 5; i++) wr(8'h20 + 8'(4 * i), 32'(c[i]));
      pins(8'h3d);
      chk("pos sel", 32'h7, 32'(pos_sel));
      chk("speed sel", 32'h0, 32'(spd_sel));
      chk("torque off", 32'h0, 32'(trq));
      @(posedge clk);
      req <= 8'h3f;
      repeat (10) @(negedge clk) n += int'(pos_trig === 1'b1);
      chk("trigger", 32'h1, 32'(n));
      rdc("status", SIFM_OFF_STAT, 32'h0000113f);
      // An unknown setting selects no mode after restart
      wr(SIFM_OFF_MODE, 32'h05);
      wr(SIFM_OFF_ACT, 32'h1);
      rdc("none", SIFM_OFF_ACT, 32'h0);
      chk("no mode", 32'h0, 32'(pos_sel));
      $display("test position done");
   endtask
   // ==========================================================
   // Hang guard, far beyond the few hundred cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_fault();
      t_disable();
      t_speed();
      t_remap();
      t_pos();
      tally_and_finish();
   end
endmodule
